// file: testbench/mpg_board_model.sv
// Board model: resolves each pin from the bank driver and the board level
`timescale 1ns/1ps
`default_nettype none
module mpg_board_model #(
  parameter int unsigned W = 8
) (
  input  wire logic [W-1:0] pin_o_i,
  input  wire logic [W-1:0] pin_oe_i,
  input  wire logic [W-1:0] board_i,
  output logic      [W-1:0] level_o
);
  // Released bits show the board pull or source, never the last driven value
  assign level_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & board_i);
endmodule // mpg_board_model
`default_nettype wire

// file: testbench/mpg_gpio_bank_sva.sv
// Checker: port-level timing and pin properties of the GPIO bank
`timescale 1ns/1ps
`default_nettype none
module mpg_gpio_bank_sva
  import mpg_pkg::*;
(
  input wire logic                        clk_sys_i,
  input wire logic                        srst_i,
  input wire logic [mpg_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [mpg_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic                        reg_wr_i,
  input wire logic                        reg_rd_i,
  input wire logic [mpg_pkg::DATA_W-1:0] reg_rdata_o,
  input wire logic                        dual_clock_mode_i,
  input wire logic                        stop_mode_i,
  input wire logic [mpg_pkg::PA_W-1:0]   port_a_pin_o,
  input wire logic [mpg_pkg::PA_W-1:0]   port_a_pin_oe_o,
  input wire logic [mpg_pkg::PB_W-1:0]   port_b_pin_o,
  input wire logic [mpg_pkg::PB_W-1:0]   port_b_pin_oe_o,
  input wire logic [mpg_pkg::PB_W-1:0]   port_b_digital_in_o,
  input wire logic [mpg_pkg::PC_W-1:0]   port_c_pin_i,
  input wire logic [mpg_pkg::PC_W-1:0]   port_c_pin_o,
  input wire logic [mpg_pkg::PC_W-1:0]   port_c_pin_oe_o,
  input wire logic                        resonator_connect_o,
  input wire logic                        port_c_stop_irq_o,
  input wire logic [mpg_pkg::PD_W-1:0]   port_d_pin_o,
  input wire logic [mpg_pkg::PD_W-1:0]   port_d_pin_oe_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  // Read data may only appear in the slot after a read strobe
  property p_rdata_idle; !$past(reg_rd_i) |-> reg_rdata_o == 8'h00; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
  property p_c_upper;
    $past(reg_rd_i) && ($past(reg_addr_i) == PORT_C_LATCH_ADDR || $past(reg_addr_i) == PORT_C_PIN_STATE_ADDR)
      |-> reg_rdata_o[7:3] == PORT_C_UNDEF_FILL;
  endproperty
  a_c_upper: assert property (p_c_upper) else $error("port C upper read bits wrong");
  property p_reso; resonator_connect_o == dual_clock_mode_i && (!dual_clock_mode_i || port_c_pin_oe_o[2:1] == 2'b00); endproperty
  a_reso: assert property (p_reso) else $error("resonator pins not released");
  property p_stop; stop_mode_i |-> !port_c_pin_oe_o[0]; endproperty
  a_stop: assert property (p_stop) else $error("stop pin driven in stop mode");
  property p_b_drive; (port_b_pin_o & ~port_b_pin_oe_o) == 8'h00; endproperty
  a_b_drive: assert property (p_b_drive) else $error("port B level without driver");
  property p_b_gate; (port_b_pin_oe_o & ~port_b_digital_in_o) == 8'h00; endproperty
  a_b_gate: assert property (p_b_gate) else $error("port B output with input blocked");
  property p_od; (port_a_pin_o & ~port_a_pin_oe_o) == 3'h0 && (port_d_pin_o & ~port_d_pin_oe_o) == 8'h00; endproperty
  a_od: assert property (p_od) else $error("high level not driven");
  property p_c_sink; port_c_pin_o == 3'h0; endproperty
  a_c_sink: assert property (p_c_sink) else $error("port C drives high");
  property p_d_clear; reg_wr_i && reg_addr_i == PORT_D_LATCH_ADDR && reg_wdata_i == 8'h00 |=> port_d_pin_o == 8'h00; endproperty
  a_d_clear: assert property (p_d_clear) else $error("port D cleared latch drives high");
  property p_rst_b; $fell(srst_i) |-> port_b_pin_oe_o == 8'h00; endproperty
  a_rst_b: assert property (p_rst_b) else $error("port B not input after reset");
  // A falling edge on pin zero must give a pulse within one to four cycles, after the synchroniser
  property p_irq; $fell(port_c_pin_i[0]) |-> ##[1:4] port_c_stop_irq_o; endproperty
  a_irq: assert property (p_irq) else $error("no interrupt pulse on falling edge");
  property p_irq_pulse; port_c_stop_irq_o |=> !port_c_stop_irq_o; endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt pulse too long");
  c_irq: cover property (port_c_stop_irq_o);
  c_stop: cover property (stop_mode_i && dual_clock_mode_i);
  c_read: cover property ($past(reg_rd_i) && reg_rdata_o != 8'h00);
endmodule // mpg_gpio_bank_sva
bind mpg_gpio_bank mpg_gpio_bank_sva u_sva (.*);
`default_nettype wire

// file: testbench/test_multi_port_gpio_bank.sv
// Testbench: register sequences and pin checks for the GPIO bank
`timescale 1ns/1ps
`default_nettype none
module test_multi_port_gpio_bank;
  import mpg_pkg::*;
  logic clk_sys_i = 1'b0, srst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0, reg_rmw_i = 1'b0;
  logic dual_clock_mode_i = 1'b0, stop_mode_i = 1'b0, resonator_connect_o, port_c_stop_irq_o;
  logic [11:0] reg_addr_i = 12'h000;
  logic [7:0] reg_wdata_i = 8'h00, reg_rdata_o, lcd_segment_i = 8'h00;
  logic [2:0] port_a_func_i = 3'h7, port_a_pin_i, port_a_pin_o, port_a_pin_oe_o, a_brd = 3'h7;
  logic [2:0] port_c_pin_i, port_c_pin_o, port_c_pin_oe_o, c_brd = 3'h7;
  logic [7:0] port_d_func_i = 8'hff, port_e_func_i = 8'hff, port_b_digital_in_o;
  logic [7:0] port_b_pin_i, port_b_pin_o, port_b_pin_oe_o, b_brd = 8'hd3;
  logic [7:0] port_d_pin_i, port_d_pin_o, port_d_pin_oe_o, d_brd = 8'hff;
  logic [7:0] port_e_pin_i, port_e_pin_o, port_e_pin_oe_o, e_brd = 8'hff;
  int n_errors = 0, total_checks = 0, irqs = 0;
  logic [11:0] ra [10] = '{PORT_A_LATCH_ADDR, PORT_A_DRV_SEL_ADDR, PORT_B_DIRECTION_ADDR, PORT_B_INPUT_GATE_ADDR,
    PORT_C_LATCH_ADDR, PORT_D_LATCH_ADDR, PORT_D_DRV_SEL_ADDR, PORT_E_LATCH_ADDR, PORT_E_DRV_SEL_ADDR, PORT_E_LCD_SEL_ADDR};
  logic [7:0] rv [10] = '{8'h07, 8'h00, 8'h00, 8'hff, 8'h07, 8'hff, 8'h00, 8'hff, 8'h00, 8'h00};
  always #5 clk_sys_i = ~clk_sys_i;
  mpg_gpio_bank uut (.*);
  mpg_board_model #(.W(3)) brd_a (.pin_o_i(port_a_pin_o), .pin_oe_i(port_a_pin_oe_o), .board_i(a_brd), .level_o(port_a_pin_i));
  mpg_board_model #(.W(8)) brd_b (.pin_o_i(port_b_pin_o), .pin_oe_i(port_b_pin_oe_o), .board_i(b_brd), .level_o(port_b_pin_i));
  mpg_board_model #(.W(3)) brd_c (.pin_o_i(port_c_pin_o), .pin_oe_i(port_c_pin_oe_o), .board_i(c_brd), .level_o(port_c_pin_i));
  mpg_board_model #(.W(8)) brd_d (.pin_o_i(port_d_pin_o), .pin_oe_i(port_d_pin_oe_o), .board_i(d_brd), .level_o(port_d_pin_i));
  mpg_board_model #(.W(8)) brd_e (.pin_o_i(port_e_pin_o), .pin_oe_i(port_e_pin_oe_o), .board_i(e_brd), .level_o(port_e_pin_i));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic m = 1'b0);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_rmw_i <= m;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
    reg_rmw_i <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1 chk(reg_rdata_o, e);
  endtask
  task automatic wrap_up;
    if (n_errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Count every pulse of the run, so a false edge after reset shows up too
  always @(posedge clk_sys_i) begin
    #1 if (port_c_stop_irq_o === 1'b1) irqs++;
  end
  // Guard against a hung sequence
  initial begin
    repeat (5000) @(posedge clk_sys_i);
    n_errors++;
    wrap_up();
  end
  initial begin
    repeat (4) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    #1 chk(port_b_pin_oe_o, 8'h00);
    chk({5'h00, port_a_pin_oe_o}, 8'h00);
    chk(port_d_pin_oe_o | port_e_pin_oe_o, 8'h00);
    for (int i = 0; i < 10; i++) rd(ra[i], rv[i]);
    wr(PORT_D_LATCH_ADDR, 8'h5a);
    #1 chk(port_d_pin_oe_o, 8'ha5);
    chk(port_d_pin_o, 8'h00);
    d_brd <= 8'h3c;
    repeat (3) @(posedge clk_sys_i);
    rd(PORT_D_PIN_STATE_ADDR, 8'h18);
    rd(PORT_D_LATCH_ADDR, 8'h5a);
    wr(PORT_D_DRV_SEL_ADDR, 8'hff);
    #1 chk(port_d_pin_oe_o, 8'hff);
    chk(port_d_pin_o, 8'h5a);
    wr(PORT_D_PIN_STATE_ADDR, 8'h00);
    rd(PORT_D_PIN_STATE_ADDR, 8'h5a);
    rd(12'h100, 8'h00);
    wr(PORT_D_LATCH_ADDR, 8'hff);
    port_d_func_i <= 8'h0f;
    #1 chk(port_d_pin_o, 8'h0f);
    @(posedge clk_sys_i);
    port_d_func_i <= 8'hff;
    wr(PORT_A_DRV_SEL_ADDR, 8'h07);
    port_a_func_i <= 3'h5;
    #1 chk({5'h00, port_a_pin_o}, 8'h05);
    @(posedge clk_sys_i);
    port_a_func_i <= 3'h7;
    wr(PORT_A_LATCH_ADDR, 8'h07);
    wr(PORT_A_DRV_SEL_ADDR, 8'h00);
    a_brd <= 3'h2;
    repeat (3) @(posedge clk_sys_i);
    rd(PORT_A_PIN_STATE_ADDR, 8'h02);
    wr(PORT_B_LATCH_ADDR, 8'ha5);
    wr(PORT_B_INPUT_GATE_ADDR, 8'h33);
    wr(PORT_B_DIRECTION_ADDR, 8'h0f);
    #1 chk(port_b_pin_oe_o, 8'h0f);
    chk(port_b_pin_o, 8'h05);
    chk(port_b_digital_in_o, 8'h3f);
    rd(PORT_B_LATCH_ADDR, 8'h15);
    wr(PORT_B_LATCH_ADDR, 8'hff, 1'b1);
    wr(PORT_B_INPUT_GATE_ADDR, 8'hff);
    wr(PORT_B_DIRECTION_ADDR, 8'hff);
    #1 chk(port_b_pin_o, 8'h1f);
    // Driving the stop pin low must still raise its interrupt
    wr(PORT_C_LATCH_ADDR, 8'h00);
    repeat (6) @(posedge clk_sys_i);
    chk(irqs[7:0], 8'h01);
    chk({5'h00, port_c_pin_oe_o}, 8'h07);
    @(posedge clk_sys_i);
    stop_mode_i <= 1'b1;
    dual_clock_mode_i <= 1'b1;
    #1 chk({5'h00, port_c_pin_oe_o}, 8'h00);
    chk({7'h00, resonator_connect_o}, 8'h01);
    repeat (3) @(posedge clk_sys_i);
    rd(PORT_C_PIN_STATE_ADDR, 8'h07);
    rd(PORT_C_LATCH_ADDR, 8'h00);
    @(posedge clk_sys_i);
    stop_mode_i <= 1'b0;
    dual_clock_mode_i <= 1'b0;
    #1 chk({5'h00, port_c_pin_oe_o}, 8'h07);
    wr(PORT_C_LATCH_ADDR, 8'h07);
    wr(PORT_E_LATCH_ADDR, 8'h00);
    lcd_segment_i <= 8'ha5;
    wr(PORT_E_LCD_SEL_ADDR, 8'h0f);
    #1 chk(port_e_pin_o, 8'h05);
    chk(port_e_pin_oe_o, 8'hff);
    wr(PORT_E_LATCH_ADDR, 8'hff);
    wr(PORT_E_LCD_SEL_ADDR, 8'h00);
    #1 chk(port_e_pin_oe_o, 8'h00);
    wrap_up();
  end
endmodule // test_multi_port_gpio_bank
`default_nettype wire

// file: verilog/mpg_gpio_bank.sv
// Top level of the multi-port GPIO bank: registers, read mux, pin control
// Overview of operation
// RQ1: Ports A and C have three pins; B, D and E have eight.
// RQ2: Reset sets port A latch to ones, driver selects to zero.
// RQ3: Driver select zero gives open drain, one gives push-pull on A, D, E.
// RQ4: A, C, D, E have pin-state registers; data register reads latch.
// RQ5: Software sets A latch then clears driver select before input use.
// RQ6: Reset clears B direction and latch, sets input gate; pins are inputs.
// RQ7: B direction one drives the latch bit; zero turns the driver off.
// RQ8: B direction zero and gate zero blocks the digital input path.
// RQ9: B read gives latch, pin level, or zero by direction and gate.
// RQ10: B bit operations write back pin levels for input bits. The code writes zero for input bits whose gate is zero.
// RQ11: Software avoids port output during conversion; analog pins stay inputs.
// RQ12: Reset sets C latch to one; input use needs latch one.
// RQ13: Dual clock mode hands C pins one and two to the resonator.
// RQ14: Falling edge of driven C pin zero still sets its interrupt latch.
// RQ15: C reads return undefined in bits seven to three.
// RQ16: STOP mode forces C pin zero to high impedance.
// RQ17: Reset sets D latch to all ones, driver selects to zero.
// RQ18: Software sets D latch before divider or serial output use.
// RQ19: Software never enables both serial functions on port D.
// RQ20: Reset sets E latch ones, driver and LCD selects zero.
// RQ21: E LCD select one outputs the segment, ignoring latch and drive.
// RQ22: Software sets E latch, clears LCD select for pulse output.
// RQ23: Pins are sampled for reads; writes update latches after the strobe.
// RQ24: Shared pin level is latch AND function output.
// RQ25: Open-drain one releases the pin so external levels can be read.
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module mpg_gpio_bank
  import mpg_pkg::*;
(
  input  wire logic                    clk_sys_i,
  input  wire logic                    srst_i,
  // Register port
  input  wire logic [mpg_pkg::ADDR_W-1:0] reg_addr_i,
  input  wire logic [mpg_pkg::DATA_W-1:0] reg_wdata_i,
  input  wire logic                    reg_wr_i,
  input  wire logic                    reg_rd_i,
  input  wire logic                    reg_rmw_i,
  output logic      [mpg_pkg::DATA_W-1:0] reg_rdata_o,
  // Mode inputs
  input  wire logic                    dual_clock_mode_i,
  input  wire logic                    stop_mode_i,
  // Peripheral function outputs, one when unused
  input  wire logic [mpg_pkg::PA_W-1:0] port_a_func_i,
  input  wire logic [mpg_pkg::PD_W-1:0] port_d_func_i,
  input  wire logic [mpg_pkg::PE_W-1:0] port_e_func_i,
  input  wire logic [mpg_pkg::PE_W-1:0] lcd_segment_i,
  // Pins
  input  wire logic [mpg_pkg::PA_W-1:0] port_a_pin_i,
  output logic      [mpg_pkg::PA_W-1:0] port_a_pin_o,
  output logic      [mpg_pkg::PA_W-1:0] port_a_pin_oe_o,
  input  wire logic [mpg_pkg::PB_W-1:0] port_b_pin_i,
  output logic      [mpg_pkg::PB_W-1:0] port_b_pin_o,
  output logic      [mpg_pkg::PB_W-1:0] port_b_pin_oe_o,
  output logic      [mpg_pkg::PB_W-1:0] port_b_digital_in_o,
  input  wire logic [mpg_pkg::PC_W-1:0] port_c_pin_i,
  output logic      [mpg_pkg::PC_W-1:0] port_c_pin_o,
  output logic      [mpg_pkg::PC_W-1:0] port_c_pin_oe_o,
  output logic                         resonator_connect_o,
  output logic                         port_c_stop_irq_o,
  input  wire logic [mpg_pkg::PD_W-1:0] port_d_pin_i,
  output logic      [mpg_pkg::PD_W-1:0] port_d_pin_o,
  output logic      [mpg_pkg::PD_W-1:0] port_d_pin_oe_o,
  input  wire logic [mpg_pkg::PE_W-1:0] port_e_pin_i,
  output logic      [mpg_pkg::PE_W-1:0] port_e_pin_o,
  output logic      [mpg_pkg::PE_W-1:0] port_e_pin_oe_o
);
  import mpg_pkg::*;

  typedef struct packed {
    logic [PA_W-1:0]   a_latch;
    logic [PA_W-1:0]   a_drv;
    logic [PA_W-1:0]   a_s1;
    logic [PA_W-1:0]   a_s2;
    logic [PB_W-1:0]   b_latch;
    logic [PB_W-1:0]   b_dir;
    logic [PB_W-1:0]   b_gate;
    logic [PB_W-1:0]   b_s1;
    logic [PB_W-1:0]   b_s2;
    logic [PC_W-1:0]   c_latch;
    logic [PC_W-1:0]   c_s1;
    logic [PC_W-1:0]   c_s2;
    logic              c0_prev;
    logic              c_irq;
    logic [PD_W-1:0]   d_latch;
    logic [PD_W-1:0]   d_drv;
    logic [PD_W-1:0]   d_s1;
    logic [PD_W-1:0]   d_s2;
    logic [PE_W-1:0]   e_latch;
    logic [PE_W-1:0]   e_drv;
    logic [PE_W-1:0]   e_lcd;
    logic [PE_W-1:0]   e_s1;
    logic [PE_W-1:0]   e_s2;
    logic [DATA_W-1:0] rdata;
  } mpg_state_t;

  mpg_state_t st_q;
  mpg_state_t st_d;

  logic [PB_W-1:0] b_read;
  logic [PB_W-1:0] b_wr_val;
  logic [PC_W-1:0] c_res_mask;
  logic [PC_W-1:0] c_hiz;
  logic [PC_W-1:0] c_ones;
  logic [PC_W-1:0] c_zeros;

  // Port B read mux, per bit
  function automatic logic [PB_W-1:0] port_b_view(input logic [PB_W-1:0] latch,
                                                   input logic [PB_W-1:0] dir,
                                                   input logic [PB_W-1:0] gate,
                                                   input logic [PB_W-1:0] pin);
    port_b_view = (dir & latch) | (~dir & gate & pin);                  // [RQ9]
  endfunction

  // Narrow ports read in bits 2:0; a constant fills the rest
  function automatic logic [DATA_W-1:0] widen_a(input logic [PA_W-1:0] val);
    widen_a = {PORT_A_ZERO_FILL, val};
  endfunction

  // Port C upper bits are undefined; reading zero keeps results repeatable
  function automatic logic [DATA_W-1:0] widen_c(input logic [PC_W-1:0] val);
    widen_c = {PORT_C_UNDEF_FILL, val};                                 // [RQ15]
  endfunction

  assign c_ones  = '1;
  assign c_zeros = '0;

  always_comb begin
    st_d = st_q;
    // Two-stage capture of every external pin
    st_d.a_s1 = port_a_pin_i;
    st_d.a_s2 = st_q.a_s1;
    st_d.b_s1 = port_b_pin_i;
    st_d.b_s2 = st_q.b_s1;
    st_d.c_s1 = port_c_pin_i;
    st_d.c_s2 = st_q.c_s1;
    st_d.d_s1 = port_d_pin_i;
    st_d.d_s2 = st_q.d_s1;
    st_d.e_s1 = port_e_pin_i;
    st_d.e_s2 = st_q.e_s1;

    b_read = port_b_view(st_q.b_latch, st_q.b_dir, st_q.b_gate, st_q.b_s2);
    // Read-modify-write sees pin levels on input bits with the gate on, so they land in the latch; gate-off input bits write zero
    b_wr_val = reg_wdata_i;
    if (reg_rmw_i) begin
      b_wr_val = (reg_wdata_i & st_q.b_dir) | (b_read & ~st_q.b_dir);  // [RQ10]
    end

    // One-cycle interrupt pulse on falling edge of pin zero, driven or not
    // Detector sees only the synchronised level, so sub-cycle glitches are lost
    st_d.c0_prev = st_q.c_s2[PC_STOP_BIT];
    st_d.c_irq   = st_q.c0_prev & ~st_q.c_s2[PC_STOP_BIT];              // [RQ14]

    // Writes land at the edge after the strobe; pin-state addresses are read only
    if (reg_wr_i) begin                                                 // [RQ23]
      case (reg_addr_i)
        PORT_A_LATCH_ADDR: begin
          st_d.a_latch = reg_wdata_i[PA_W-1:0];
        end
        PORT_A_DRV_SEL_ADDR: begin
          st_d.a_drv = reg_wdata_i[PA_W-1:0];
        end
        PORT_B_LATCH_ADDR: begin
          st_d.b_latch = b_wr_val;
        end
        PORT_B_DIRECTION_ADDR: begin
          st_d.b_dir = reg_wdata_i;
        end
        PORT_B_INPUT_GATE_ADDR: begin
          st_d.b_gate = reg_wdata_i;
        end
        PORT_C_LATCH_ADDR: begin
          st_d.c_latch = reg_wdata_i[PC_W-1:0];
        end
        PORT_D_LATCH_ADDR: begin
          st_d.d_latch = reg_wdata_i;
        end
        PORT_D_DRV_SEL_ADDR: begin
          st_d.d_drv = reg_wdata_i;
        end
        PORT_E_LATCH_ADDR: begin
          st_d.e_latch = reg_wdata_i;
        end
        PORT_E_DRV_SEL_ADDR: begin
          st_d.e_drv = reg_wdata_i;
        end
        PORT_E_LCD_SEL_ADDR: begin
          st_d.e_lcd = reg_wdata_i;
        end
        default: begin
        end
      endcase
    end

    // Read data valid only in the cycle after the strobe
    st_d.rdata = '0;
    if (reg_rd_i) begin
      case (reg_addr_i)
        PORT_A_LATCH_ADDR: begin
          st_d.rdata = widen_a(st_q.a_latch);                           // [RQ4]
        end
        PORT_A_DRV_SEL_ADDR: begin
          st_d.rdata = widen_a(st_q.a_drv);
        end
        PORT_A_PIN_STATE_ADDR: begin
          st_d.rdata = widen_a(st_q.a_s2);                              // [RQ4]
        end
        PORT_B_LATCH_ADDR: begin
          st_d.rdata = b_read;                                          // [RQ9]
        end
        PORT_B_DIRECTION_ADDR: begin
          st_d.rdata = st_q.b_dir;
        end
        PORT_B_INPUT_GATE_ADDR: begin
          st_d.rdata = st_q.b_gate;
        end
        PORT_C_LATCH_ADDR: begin
          st_d.rdata = widen_c(st_q.c_latch);                           // [RQ4] [RQ15]
        end
        PORT_C_PIN_STATE_ADDR: begin
          st_d.rdata = widen_c(st_q.c_s2);                              // [RQ15]
        end
        PORT_D_LATCH_ADDR: begin
          st_d.rdata = st_q.d_latch;                                    // [RQ4]
        end
        PORT_D_DRV_SEL_ADDR: begin
          st_d.rdata = st_q.d_drv;
        end
        PORT_D_PIN_STATE_ADDR: begin
          st_d.rdata = st_q.d_s2;                                       // [RQ4]
        end
        PORT_E_LATCH_ADDR: begin
          st_d.rdata = st_q.e_latch;                                    // [RQ4]
        end
        PORT_E_DRV_SEL_ADDR: begin
          st_d.rdata = st_q.e_drv;
        end
        PORT_E_LCD_SEL_ADDR: begin
          st_d.rdata = st_q.e_lcd;
        end
        PORT_E_PIN_STATE_ADDR: begin
          st_d.rdata = st_q.e_s2;                                       // [RQ4]
        end
        default:                st_d.rdata = '0;
      endcase
    end

    // Reset last, so it overrides any access in the same cycle
    if (srst_i) begin
      st_d         = '0;
      st_d.a_latch = PORT_A_LATCH_RST;                                  // [RQ2]
      st_d.a_drv   = PORT_A_DRV_SEL_RST;                                // [RQ2]
      st_d.b_latch = PORT_B_LATCH_RST;                                  // [RQ6]
      st_d.b_dir   = PORT_B_DIRECTION_RST;                              // [RQ6]
      st_d.b_gate  = PORT_B_INPUT_GATE_RST;                             // [RQ6]
      st_d.c_latch = PORT_C_LATCH_RST;                                  // [RQ12]
      // Matches the cleared synchroniser, so no false edge follows reset
      st_d.c0_prev = 1'b0;                                              // [RQ14]
      st_d.d_latch = PORT_D_LATCH_RST;                                  // [RQ17]
      st_d.d_drv   = PORT_D_DRV_SEL_RST;                                // [RQ17]
      st_d.e_latch = PORT_E_LATCH_RST;                                  // [RQ20]
      st_d.e_drv   = PORT_E_DRV_SEL_RST;                                // [RQ20]
      st_d.e_lcd   = PORT_E_LCD_SEL_RST;                                // [RQ20]
    end
  end

  // One register stage holds all state, reset included
  always_ff @(posedge clk_sys_i) begin
    st_q <= st_d;
  end

  assign reg_rdata_o = st_q.rdata;

  // Port B: push-pull when output, driver off when input
  assign port_b_pin_o        = st_q.b_latch & st_q.b_dir;               // [RQ7]
  assign port_b_pin_oe_o     = st_q.b_dir;                              // [RQ7]
  assign port_b_digital_in_o = st_q.b_dir | st_q.b_gate;                // [RQ8]

  // Port C: resonator pins and STOP pin released as needed
  always_comb begin
    c_res_mask = '0;
    if (dual_clock_mode_i) begin
      c_res_mask[PC_LOW_FREQ_RESONATOR_IN_BIT] = 1'b1;                                   // [RQ13]
      c_res_mask[PC_LOW_FREQ_RESONATOR_OUT_BIT] = 1'b1;                                   // [RQ13]
    end
    // STOP release overrides the latch on pin zero only
    c_hiz = c_res_mask;
    c_hiz[PC_STOP_BIT] = stop_mode_i;                                   // [RQ16]
  end

  assign resonator_connect_o = dual_clock_mode_i;                       // [RQ13]
  assign port_c_stop_irq_o   = st_q.c_irq;                              // [RQ14]

  // Port C has no driver select; latch one releases the pin for input use
  mpg_pin_drv #(.W(PC_W)) u_port_c (
    .latch_i    (st_q.c_latch),                                         // [RQ12]
    .func_i     (c_ones),
    .cmos_sel_i (c_zeros),
    .lcd_sel_i  (c_zeros),
    .lcd_seg_i  (c_zeros),
    .hiz_i      (c_hiz),
    .pin_o      (port_c_pin_o),
    .pin_oe_o   (port_c_pin_oe_o)
  );

  // Ports A, D and E share one driver cell; only the selects differ
  mpg_pin_drv #(.W(PA_W)) u_port_a (                                    // [RQ1]
    .latch_i    (st_q.a_latch),
    .func_i     (port_a_func_i),
    .cmos_sel_i (st_q.a_drv),                                           // [RQ3]
    .lcd_sel_i  ({PA_W{1'b0}}),
    .lcd_seg_i  ({PA_W{1'b0}}),
    .hiz_i      ({PA_W{1'b0}}),
    .pin_o      (port_a_pin_o),
    .pin_oe_o   (port_a_pin_oe_o)
  );

  mpg_pin_drv #(.W(PD_W)) u_port_d (
    .latch_i    (st_q.d_latch),
    .func_i     (port_d_func_i),
    .cmos_sel_i (st_q.d_drv),                                           // [RQ3]
    .lcd_sel_i  ({PD_W{1'b0}}),
    .lcd_seg_i  ({PD_W{1'b0}}),
    .hiz_i      ({PD_W{1'b0}}),
    .pin_o      (port_d_pin_o),
    .pin_oe_o   (port_d_pin_oe_o)
  );

  mpg_pin_drv #(.W(PE_W)) u_port_e (
    .latch_i    (st_q.e_latch),
    .func_i     (port_e_func_i),
    .cmos_sel_i (st_q.e_drv),                                           // [RQ3]
    .lcd_sel_i  (st_q.e_lcd),                                           // [RQ21]
    .lcd_seg_i  (lcd_segment_i),
    .hiz_i      ({PE_W{1'b0}}),
    .pin_o      (port_e_pin_o),
    .pin_oe_o   (port_e_pin_oe_o)
  );
endmodule : mpg_gpio_bank
`default_nettype wire

// file: verilog/mpg_pin_drv.sv
// Per-bit pin driver: open-drain or push-pull, shared function, LCD override
`timescale 1ns/1ps
`default_nettype none
module mpg_pin_drv #(
  parameter int unsigned W = 8
) (
  input  wire logic [W-1:0] latch_i,
  input  wire logic [W-1:0] func_i,
  input  wire logic [W-1:0] cmos_sel_i,
  input  wire logic [W-1:0] lcd_sel_i,
  input  wire logic [W-1:0] lcd_seg_i,
  input  wire logic [W-1:0] hiz_i,
  output logic      [W-1:0] pin_o,
  output logic      [W-1:0] pin_oe_o
);
  logic [W-1:0] level;

  always_comb begin
    level = latch_i & func_i;                                           // [RQ24]
    for (int i = 0; i < W; i++) begin
      if (hiz_i[i]) begin
        pin_o[i]    = 1'b0;
        pin_oe_o[i] = 1'b0;
      end else if (lcd_sel_i[i]) begin
        pin_o[i]    = lcd_seg_i[i];                                     // [RQ21]
        pin_oe_o[i] = 1'b1;
      end else if (cmos_sel_i[i]) begin
        pin_o[i]    = level[i];                                         // [RQ3]
        pin_oe_o[i] = 1'b1;
      end else begin
        // Open drain only sinks; a one releases the pin
        pin_o[i]    = 1'b0;
        pin_oe_o[i] = ~level[i];                                        // [RQ3] [RQ25]
      end
    end
  end
endmodule : mpg_pin_drv
`default_nettype wire

// file: verilog/mpg_pkg.sv
// Package: register map, reset values and widths for the multi-port GPIO bank
package mpg_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 8;

  // Port widths
  localparam int unsigned PA_W = 3;
  localparam int unsigned PB_W = 8;
  localparam int unsigned PC_W = 3;
  localparam int unsigned PD_W = 8;
  localparam int unsigned PE_W = 8;

  // Register offsets
  localparam logic [ADDR_W-1:0] PORT_A_LATCH_ADDR      = 12'h000;
  localparam logic [ADDR_W-1:0] PORT_B_LATCH_ADDR      = 12'h001;
  localparam logic [ADDR_W-1:0] PORT_C_LATCH_ADDR      = 12'h002;
  localparam logic [ADDR_W-1:0] PORT_D_LATCH_ADDR      = 12'h003;
  localparam logic [ADDR_W-1:0] PORT_E_LATCH_ADDR      = 12'h004;
  localparam logic [ADDR_W-1:0] PORT_D_DRV_SEL_ADDR    = 12'h02b;
  localparam logic [ADDR_W-1:0] PORT_A_DRV_SEL_ADDR    = 12'h032;
  localparam logic [ADDR_W-1:0] PORT_E_LCD_SEL_ADDR    = 12'hfd4;
  localparam logic [ADDR_W-1:0] PORT_A_PIN_STATE_ADDR  = 12'hff0;
  localparam logic [ADDR_W-1:0] PORT_C_PIN_STATE_ADDR  = 12'hff2;
  localparam logic [ADDR_W-1:0] PORT_D_PIN_STATE_ADDR  = 12'hff3;
  localparam logic [ADDR_W-1:0] PORT_E_PIN_STATE_ADDR  = 12'hff4;
  localparam logic [ADDR_W-1:0] PORT_B_DIRECTION_ADDR  = 12'hff9;
  localparam logic [ADDR_W-1:0] PORT_B_INPUT_GATE_ADDR = 12'hffa;
  localparam logic [ADDR_W-1:0] PORT_E_DRV_SEL_ADDR    = 12'hffb;

  // Reset values
  localparam logic [PA_W-1:0] PORT_A_LATCH_RST      = 3'h7;
  localparam logic [PA_W-1:0] PORT_A_DRV_SEL_RST    = 3'h0;
  localparam logic [PB_W-1:0] PORT_B_LATCH_RST      = 8'h00;
  localparam logic [PB_W-1:0] PORT_B_DIRECTION_RST  = 8'h00;
  localparam logic [PB_W-1:0] PORT_B_INPUT_GATE_RST = 8'hff;
  localparam logic [PC_W-1:0] PORT_C_LATCH_RST      = 3'h7;
  localparam logic [PD_W-1:0] PORT_D_LATCH_RST      = 8'hff;
  localparam logic [PD_W-1:0] PORT_D_DRV_SEL_RST    = 8'h00;
  localparam logic [PE_W-1:0] PORT_E_LATCH_RST      = 8'hff;
  localparam logic [PE_W-1:0] PORT_E_DRV_SEL_RST    = 8'h00;
  localparam logic [PE_W-1:0] PORT_E_LCD_SEL_RST    = 8'h00;

  // Fill for undefined upper bits of port C reads
  localparam logic [DATA_W-PC_W-1:0] PORT_C_UNDEF_FILL = 5'h00;
  // Filler for the 3-bit port A read-back
  localparam logic [DATA_W-PA_W-1:0] PORT_A_ZERO_FILL  = 5'h00;

  // Port C bit positions
  localparam int unsigned PC_STOP_BIT = 0;
  localparam int unsigned PC_LOW_FREQ_RESONATOR_IN_BIT = 1;
  localparam int unsigned PC_LOW_FREQ_RESONATOR_OUT_BIT = 2;
endpackage : mpg_pkg
